// [design/apsr_core.sv]
// Audio port strobe-mode receiver with control, status and APB register file
`timescale 1ns/1ps
// How it works
// - Strobe mode receive only, enabled by bit
// - Data and strobe pins, bit per change
// - Shift bits in, push each 32-bit word
// - Strobe words obey normal receive thresholds
// - Flush pushes partial word, reads zero
// - Flushed word zero padded to 32 bits
// - Flushed count reports valid bit number
// - In control_status only low three bits and error clears act while running
// - RAM standby resets to zero, standby active
// - Sync echo after two serial clocks
// - Optional sign extension from channel width
// - Bit 22 shows receive FIFO full
// - Bit 21 shows transmit FIFO empty
// - Bit 20 shows receive FIFO has data
// - Bit 19 shows transmit FIFO has room
// - Bit 18 receive level at threshold
// - Bit 17 transmit level below threshold
// - Bits 16,15 latch errors, write one clears
// - Bits 14,13 whole frames in FIFO
// - Receive DMA request above request level
module apsr_core
   import apsr_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic      [31:0] prdata,
   output logic             pslverr,
   input  wire logic        link_clk,
   input  wire logic        data_pin,
   input  wire logic        frame_sync_pin,
   input  wire logic        pcm_rx_valid,
   input  wire logic [31:0] pcm_rx_data,
   input  wire logic        rx_mid_frame,
   input  wire logic        tx_mid_frame,
   input  wire logic        tx_pop,
   output logic      [31:0] tx_data,
   output logic             rx_dma_req,
   output logic             tx_dma_req,
   output logic             ram_standby,
   output logic             port_enable,
   output logic             rx_on,
   output logic             tx_on
);
   localparam int CW = $clog2(DEPTH+1);
   if (DEPTH > 127) begin : g_chk
      $error("FIFO depth must fit the seven-bit request levels");
   end

   typedef struct packed {
      logic                             en;
      logic                             rxon;
      logic                             txon;
      logic [1:0]                       tx_thresh;
      logic [1:0]                       rx_thresh;
      logic                             dmaen;
      logic                             sex;
      logic                             ram_active;
      logic                             sync_wr;
      logic                             sync_e1;
      logic                             sync_e2;
      logic                             rx_error;
      logic                             tx_error;
      logic                             si_en;
      apsr_flush_t                      flush;
      logic [5:0]                       flushed;
      logic [5:0]                       level;
      logic [31:0]                      shreg;
      logic                             link_q;
      logic                             din_q;
      logic                             fs_q;
      logic [MISC_WORDS-1:0][31:0]      misc;
      logic [31:0]                      rdata;
   } apsr_core_t;

   apsr_core_t s;
   apsr_core_t next_s;

   logic [2:0]    pins_s;
   logic          link_s;
   logic          din_s;
   logic          fs_s;
   logic          rx_push_valid;
   logic          rx_push_ready;
   logic [31:0]   rx_push_data;
   logic          rx_pop_valid;
   logic          rx_pop_ready;
   logic [31:0]   rx_pop_data;
   logic [CW-1:0] rx_cnt;
   logic          tx_push_valid;
   logic          tx_push_ready;
   logic          tx_pop_valid;
   logic [CW-1:0] tx_cnt;
   logic          rx_clear;
   logic          tx_clear;
   logic          apb_wr;
   logic          apb_rd;
   logic          link_rise;
   logic          bit_now;
   logic          strobe_push;
   logic [31:0]   strobe_word;
   logic [31:0]   cur_sh;
   logic [5:0]    cur_lvl;
   logic          running;
   logic          rx_full;
   logic          tx_empty;
   logic          rx_need;
   logic          tx_need;
   logic          rx_aligned;
   logic          tx_aligned;
   logic [31:0]   cs_view;
   logic [31:0]   si_view;
   logic [2:0]    misc_idx;
   logic [31:0]   rxc;
   logic [31:0]   dreq;

   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a <= OFF_LAST) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [31:0] sign_ext(input logic [31:0] d, input logic [4:0] msb, input logic en);
      logic [31:0] r;
      r = d;
      if (en) begin
         for (int i = 1; i < 32; i++) begin
            if (i > int'(msb)) begin
               r[i] = d[msb];
            end
         end
      end
      sign_ext = r;
   endfunction

   function automatic logic [CW-1:0] frac(input int num);
      frac = CW'((DEPTH * num) / 4);
   endfunction

   // Link clock is sampled, not used as a clock; makes edge sampling safe
   apsr_sync #(
      .WIDTH(3)
   ) u_sync (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .async_in ({link_clk, data_pin, frame_sync_pin}),
      .sync_out (pins_s)
   );
   assign link_s = pins_s[2];
   assign din_s = pins_s[1];
   assign fs_s = pins_s[0];

   apsr_fifo #(
      .WIDTH(WORD_BITS),
      .DEPTH(DEPTH)
   ) u_rx_fifo (
      .sys_clk    (sys_clk),
      .rst_b      (rst_b),
      .clear      (rx_clear),
      .push_valid (rx_push_valid),
      .push_ready (rx_push_ready),
      .push_data  (rx_push_data),
      .pop_valid  (rx_pop_valid),
      .pop_ready  (rx_pop_ready),
      .pop_data   (rx_pop_data),
      .count      (rx_cnt)
   );

   apsr_fifo #(
      .WIDTH(WORD_BITS),
      .DEPTH(DEPTH)
   ) u_tx_fifo (
      .sys_clk    (sys_clk),
      .rst_b      (rst_b),
      .clear      (tx_clear),
      .push_valid (tx_push_valid),
      .push_ready (tx_push_ready),
      .push_data  (pwdata),
      .pop_valid  (tx_pop_valid),
      .pop_ready  (tx_pop),
      .pop_data   (tx_data),
      .count      (tx_cnt)
   );

   always_comb begin
      next_s = s;
      apb_wr = psel && penable && pwrite;
      apb_rd = psel && penable && !pwrite;
      running = s.rxon || s.txon;
      rxc = s.misc[MISC_RXC];
      dreq = s.misc[MISC_DREQ];
      misc_idx = paddr[4:2] - MISC_BASE;
      link_rise = link_s && !s.link_q;
      next_s.link_q = link_s;

      // Echo moves one stage per serial clock
      if (link_rise) begin
         next_s.sync_e1 = s.sync_wr;
         next_s.sync_e2 = s.sync_e1;
      end

      // Strobe receiver: levels latched only at serial clock edges
      if (link_rise) begin
         next_s.din_q = din_s;
         next_s.fs_q = fs_s;
      end
      bit_now = link_rise && s.si_en && ((din_s != s.din_q) || (fs_s != s.fs_q));
      cur_sh = s.shreg;
      cur_lvl = s.level;
      strobe_push = 1'b0;
      if (bit_now) begin
         cur_sh = {s.shreg[30:0], din_s};
         cur_lvl = s.level + 6'd1;
      end
      strobe_word = cur_sh;
      if (cur_lvl == 6'(WORD_BITS)) begin
         strobe_push = 1'b1;
         cur_sh = '0;
         cur_lvl = '0;
      end else if (link_rise && s.flush == APSR_FL_WAIT) begin
         // Upper bits are already zero since the buffer clears per word
         strobe_push = (cur_lvl != '0);
         next_s.flushed = cur_lvl;
         cur_sh = '0;
         cur_lvl = '0;
         next_s.flush = APSR_FL_IDLE;
      end
      next_s.shreg = cur_sh;
      next_s.level = cur_lvl;

      // Strobe words share the normal receive path and its thresholds
      rx_push_valid = strobe_push || (pcm_rx_valid && s.rxon && !s.si_en);
      rx_push_data = strobe_push ? strobe_word : sign_ext(pcm_rx_data, rxc[RXC_WID +: 5], s.sex);

      rx_pop_ready = apb_rd && (paddr == OFF_FIFO_DATA_PORT);
      tx_push_valid = apb_wr && (paddr == OFF_FIFO_DATA_PORT);
      rx_clear = apb_wr && (paddr == OFF_CONTROL_STATUS) && !running && pwdata[CS_RXCLR];
      tx_clear = apb_wr && (paddr == OFF_CONTROL_STATUS) && !running && pwdata[CS_TXCLR];

      // Status flags
      rx_full = (rx_cnt == CW'(DEPTH));
      tx_empty = (tx_cnt == '0);
      case (s.rx_thresh)
         2'd0: rx_need = (rx_cnt != '0);
         2'd1: rx_need = (rx_cnt >= frac(1));
         2'd2: rx_need = (rx_cnt >= frac(3));
         default: rx_need = rx_full;
      endcase
      case (s.tx_thresh)
         2'd0: tx_need = tx_empty;
         2'd1: tx_need = (tx_cnt < frac(1));
         2'd2: tx_need = (tx_cnt < frac(3));
         default: tx_need = (tx_cnt < CW'(DEPTH));
      endcase
      // Odd word count is balanced by a half-done frame
      rx_aligned = !rxc[RXC_TWO_CH] || (rx_cnt[0] == rx_mid_frame);
      tx_aligned = !rxc[RXC_TWO_CH] || (tx_cnt[0] == tx_mid_frame);

      cs_view = '0;
      cs_view[CS_EN] = s.en;
      cs_view[CS_RXON] = s.rxon;
      cs_view[CS_TXON] = s.txon;
      cs_view[CS_TX_THRESH +: 2] = s.tx_thresh;
      cs_view[CS_RX_THRESH +: 2] = s.rx_thresh;
      cs_view[CS_DMAEN] = s.dmaen;
      cs_view[CS_TX_ALIGNED] = tx_aligned;
      cs_view[CS_RX_ALIGNED] = rx_aligned;
      cs_view[CS_TX_ERROR] = s.tx_error;
      cs_view[CS_RX_ERROR] = s.rx_error;
      cs_view[CS_TX_NEED] = tx_need;
      cs_view[CS_RX_NEED] = rx_need;
      cs_view[CS_TXD] = (tx_cnt != CW'(DEPTH));
      cs_view[CS_RXD] = (rx_cnt != '0);
      cs_view[CS_TX_EMPTY] = tx_empty;
      cs_view[CS_RX_FULL] = rx_full;
      cs_view[CS_SEX] = s.sex;
      cs_view[CS_SYNC] = s.sync_e2;
      cs_view[CS_STANDBY] = s.ram_active;

      // Flush bit never reads back as one
      si_view = '0;
      si_view[SI_EN] = s.si_en;
      si_view[SI_FLUSHED +: 6] = s.flushed;
      si_view[SI_LEVEL +: 6] = s.level;

      // Read data is staged in the setup phase so prdata comes from a flop
      if (psel && !penable && !pwrite) begin
         next_s.rdata = '0;
         if (reg_hit(paddr)) begin
            case (paddr)
               OFF_CONTROL_STATUS: next_s.rdata = cs_view;
               OFF_FIFO_DATA_PORT: next_s.rdata = rx_pop_valid ? rx_pop_data : '0;
               OFF_STROBE_INPUT_CONTROL: next_s.rdata = si_view;
               default: next_s.rdata = s.misc[misc_idx];
            endcase
         end
      end

      if (apb_wr && paddr == OFF_CONTROL_STATUS) begin
         next_s.en = pwdata[CS_EN];
         next_s.rxon = pwdata[CS_RXON];
         next_s.txon = pwdata[CS_TXON];
         if (!running) begin
            next_s.tx_thresh = pwdata[CS_TX_THRESH +: 2];
            next_s.rx_thresh = pwdata[CS_RX_THRESH +: 2];
            next_s.dmaen = pwdata[CS_DMAEN];
            next_s.sex = pwdata[CS_SEX];
            next_s.sync_wr = pwdata[CS_SYNC];
            next_s.ram_active = pwdata[CS_STANDBY];
         end
      end
      if (apb_wr && paddr == OFF_STROBE_INPUT_CONTROL) begin
         next_s.si_en = pwdata[SI_EN];
         if (pwdata[SI_FLUSH]) begin
            next_s.flush = APSR_FL_WAIT;
         end
      end
      if (apb_wr && reg_hit(paddr) && paddr >= OFF_OPERATING_MODE && paddr < OFF_STROBE_INPUT_CONTROL) begin
         next_s.misc[misc_idx] = pwdata;
      end

      // Errors: a new event in the clearing cycle wins
      next_s.rx_error = (s.rx_error && !(apb_wr && paddr == OFF_CONTROL_STATUS && pwdata[CS_RX_ERROR]))
                     || (rx_push_valid && !rx_push_ready) || (rx_pop_ready && !rx_pop_valid);
      next_s.tx_error = (s.tx_error && !(apb_wr && paddr == OFF_CONTROL_STATUS && pwdata[CS_TX_ERROR]))
                     || (tx_push_valid && !tx_push_ready) || (tx_pop && !tx_pop_valid);
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.ram_active <= RST_STANDBY;
         s.sync_wr <= RST_SYNC;
      end else begin
         s <= next_s;
      end
   end

   assign pready = 1'b1;
   assign prdata = s.rdata;
   assign pslverr = psel && penable && !reg_hit(paddr);
   assign rx_dma_req = s.dmaen && (7'(rx_cnt) > dreq[DREQ_RX +: 7]);
   assign tx_dma_req = s.dmaen && (7'(tx_cnt) < dreq[DREQ_TX +: 7]);
   // Standby output is active while the control bit is still zero
   assign ram_standby = !s.ram_active;
   assign port_enable = s.en;
   assign rx_on = s.rxon;
   assign tx_on = s.txon;
endmodule

// [design/apsr_fifo.sv]
// Flip-flop FIFO with push and pop handshakes and a fill count
`timescale 1ns/1ps
module apsr_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 64
) (
   input  wire logic                       sys_clk,
   input  wire logic                       rst_b,
   input  wire logic                       clear,
   input  wire logic                       push_valid,
   output logic                            push_ready,
   input  wire logic [WIDTH-1:0]           push_data,
   output logic                            pop_valid,
   input  wire logic                       pop_ready,
   output logic      [WIDTH-1:0]           pop_data,
   output logic      [$clog2(DEPTH+1)-1:0] count
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_chk
      $error("FIFO depth must be a power of two of at least four");
   end
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [CW-1:0]               cnt;
   } apsr_fifo_t;
   apsr_fifo_t s;
   apsr_fifo_t next_s;
   logic       do_push;
   logic       do_pop;

   always_comb begin
      next_s = s;
      do_push = push_valid && push_ready;
      do_pop = pop_valid && pop_ready;
      if (do_push) begin
         next_s.mem[s.wr] = push_data;
         next_s.wr = s.wr + 1'b1;
      end
      if (do_pop) begin
         next_s.rd = s.rd + 1'b1;
      end
      next_s.cnt = s.cnt + CW'(do_push) - CW'(do_pop);
      if (clear) begin
         next_s.wr = '0;
         next_s.rd = '0;
         next_s.cnt = '0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign push_ready = (s.cnt != CW'(DEPTH));
   assign pop_valid = (s.cnt != '0);
   assign pop_data = s.mem[s.rd];
   assign count = s.cnt;
endmodule

// [design/apsr_pkg.sv]
// Shared constants and types for the audio port strobe receiver and status block
package apsr_pkg;
   localparam int WORD_BITS = 32;
   localparam int FIFO_DEPTH = 64;
   // Register byte offsets
   localparam logic [7:0] OFF_CONTROL_STATUS = 8'h00;
   localparam logic [7:0] OFF_FIFO_DATA_PORT = 8'h04;
   localparam logic [7:0] OFF_OPERATING_MODE = 8'h08;
   localparam logic [7:0] OFF_RECEIVE_CONFIG = 8'h0c;
   localparam logic [7:0] OFF_TRANSMIT_CONFIG = 8'h10;
   localparam logic [7:0] OFF_DMA_REQUEST_LEVEL = 8'h14;
   localparam logic [7:0] OFF_INTERRUPT_ENABLES = 8'h18;
   localparam logic [7:0] OFF_INTERRUPT_STATUS_CLEAR = 8'h1c;
   localparam logic [7:0] OFF_STROBE_INPUT_CONTROL = 8'h20;
   localparam logic [7:0] OFF_LAST = 8'h20;
   // Plain storage words from operating_mode upward, index = offset/4 - 2
   localparam int MISC_WORDS = 6;
   localparam logic [2:0] MISC_BASE = 3'h2;
   localparam logic [2:0] MISC_RXC = 3'h1;
   localparam logic [2:0] MISC_DREQ = 3'h3;
   // control_status field positions
   localparam int CS_EN = 0;
   localparam int CS_RXON = 1;
   localparam int CS_TXON = 2;
   localparam int CS_TXCLR = 3;
   localparam int CS_RXCLR = 4;
   localparam int CS_TX_THRESH = 5;
   localparam int CS_RX_THRESH = 7;
   localparam int CS_DMAEN = 9;
   localparam int CS_TX_ALIGNED = 13;
   localparam int CS_RX_ALIGNED = 14;
   localparam int CS_TX_ERROR = 15;
   localparam int CS_RX_ERROR = 16;
   localparam int CS_TX_NEED = 17;
   localparam int CS_RX_NEED = 18;
   localparam int CS_TXD = 19;
   localparam int CS_RXD = 20;
   localparam int CS_TX_EMPTY = 21;
   localparam int CS_RX_FULL = 22;
   localparam int CS_SEX = 23;
   localparam int CS_SYNC = 24;
   localparam int CS_STANDBY = 25;
   // Reset values of control_status storage
   localparam logic RST_STANDBY = 1'b0;
   localparam logic RST_SYNC = 1'b0;
   // strobe_input_control field positions
   localparam int SI_EN = 0;
   localparam int SI_FLUSH = 1;
   localparam int SI_FLUSHED = 4;
   localparam int SI_LEVEL = 10;
   // receive_config: channel width minus one, two-channel frame flag
   localparam int RXC_WID = 0;
   localparam int RXC_TWO_CH = 5;
   // dma_request_level: receive and transmit request levels, 7 bits each
   localparam int DREQ_RX = 0;
   localparam int DREQ_TX = 8;
   typedef enum logic {
      APSR_FL_IDLE = 1'b0,
      APSR_FL_WAIT = 1'b1
   } apsr_flush_t;
endpackage

// [design/apsr_sync.sv]
// Two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module apsr_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } apsr_sync_t;
   apsr_sync_t s;
   apsr_sync_t next_s;

   always_comb begin
      next_s.s1 = async_in;
      next_s.s2 = s.s1;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sync_out = s.s2;
endmodule

// [test/apsr_core_chk.sv]
// Concurrent checks on the strobe receiver's register and control ports
`timescale 1ns/1ps
module apsr_core_chk
   import apsr_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        ram_standby,
   input wire logic        rx_on,
   input wire logic        tx_on
);
   logic cs_wr;
   logic cs_rd;
   logic running;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   assign cs_wr = psel && penable && pwrite && paddr == OFF_CONTROL_STATUS;
   assign cs_rd = psel && penable && !pwrite && paddr == OFF_CONTROL_STATUS;
   assign running = rx_on || tx_on;
   a_standby_reset: assert property ($rose(rst_b) |-> ram_standby)
      else $error("ram standby not active after reset");
   a_standby_write: assert property (cs_wr && !running |=> ram_standby == !$past(pwdata[CS_STANDBY]))
      else $error("ram standby does not follow written bit");
   a_standby_held: assert property (cs_wr && running |=> $stable(ram_standby))
      else $error("standby changed while running");
   a_standby_cause: assert property ($changed(ram_standby) |-> $past(cs_wr))
      else $error("standby changed without a write");
   a_low_bits_live: assert property (cs_wr |=> rx_on == $past(pwdata[CS_RXON]) && tx_on == $past(pwdata[CS_TXON]))
      else $error("low control bits not taken");
   a_flush_reads_zero: assert property (psel && penable && !pwrite && paddr == OFF_STROBE_INPUT_CONTROL
                                        |-> !prdata[SI_FLUSH])
      else $error("flush bit read back as one");
   a_full_has_data: assert property (cs_rd && prdata[CS_RX_FULL] |-> prdata[CS_RXD])
      else $error("full flag without data flag");
   a_empty_has_room: assert property (cs_rd && prdata[CS_TX_EMPTY] |-> prdata[CS_TXD] && prdata[CS_TX_NEED])
      else $error("empty flag without room flags");
   a_ready_has_data: assert property (cs_rd && prdata[CS_RX_NEED] |-> prdata[CS_RXD])
      else $error("needs-read flag without data");
   cover property (cs_wr && running);
   cover property (cs_rd && prdata[CS_RX_FULL]);
   cover property ($fell(ram_standby));
endmodule

// [test/apsr_core_tb.sv]
// Self-checking bench for the strobe receiver and status block
`timescale 1ns/1ps
module apsr_core_tb;
   import apsr_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic        pready;
   logic [31:0] prdata;
   logic        link_clk;
   logic        data_pin;
   logic        frame_sync_pin;
   logic        pcm_rx_valid = 1'b0;
   logic [31:0] pcm_rx_data = 32'h0;
   logic        tx_pop = 1'b0;
   logic        rx_dma_req;
   logic        ram_standby;
   logic        rx_on;
   logic        rx_mid_frame = 1'b0;
   logic        tx_mid_frame = 1'b0;
   logic        pslverr;
   logic        slv_err;
   logic        tx_dma_req;
   logic        port_enable;
   logic        tx_on;
   logic [31:0] tx_data;
   logic [31:0] rd;
   int          n_errors = 0;
   int          total_checks = 0;
   int          cycles = 0;
   // Small FIFO so that full and overflow are reached quickly
   localparam int DEPTH_TB = 4;
   localparam logic [31:0] CS_BASE = 32'h02800201;
   always #5 sys_clk = ~sys_clk;
   apsr_core #(.DEPTH(DEPTH_TB)) uut (
      .sys_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
      .pslverr, .link_clk, .data_pin, .frame_sync_pin, .pcm_rx_valid, .pcm_rx_data,
      .rx_mid_frame, .tx_mid_frame, .tx_pop, .tx_data, .rx_dma_req,
      .tx_dma_req, .ram_standby, .port_enable, .rx_on, .tx_on
   );
   apsr_strobe_src src (.link_clk, .data_pin, .frame_sync_pin);
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      q = prdata;
      slv_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge: next call never re-drives psel in the same step
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0, rd);
      chk(name, rd & m, e);
   endtask
   task automatic pcm(input logic [31:0] d);
      pcm_rx_valid <= 1'b1;
      pcm_rx_data <= d;
      @(posedge sys_clk);
      pcm_rx_valid <= 1'b0;
      @(posedge sys_clk);
   endtask
   initial begin
      int n;
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rd_chk("cs reset", OFF_CONTROL_STATUS, 32'h03ff8000, 32'h002a0000);
      chk("standby pin", ram_standby, 1'b1);
      apb(1'b0, 8'h24, 32'h0, rd);
      chk("unmapped error", slv_err, 1'b1);
      chk("unmapped data", rd, 32'h0);
      $display("test reset done");
      wr(OFF_STROBE_INPUT_CONTROL, 32'h1);
      src.send(32'ha5c30f96, 32);
      rd_chk("rx data flag", OFF_CONTROL_STATUS, 32'h00100000, 32'h00100000);
      rd_chk("strobe word", OFF_FIFO_DATA_PORT, 32'hffffffff, 32'ha5c30f96);
      src.send(32'h16, 5);
      rd_chk("level", OFF_STROBE_INPUT_CONTROL, 32'h0000fc00, 32'h00001400);
      wr(OFF_STROBE_INPUT_CONTROL, 32'h3);
      n = 0;
      do begin
         apb(1'b0, OFF_STROBE_INPUT_CONTROL, 32'h0, rd);
         n++;
      end while (rd[9:4] !== 6'h05 && n < 100);
      chk("flushed count", rd & 32'h0000fff2, 32'h00000050);
      rd_chk("flushed word", OFF_FIFO_DATA_PORT, 32'hffffffff, 32'h00000016);
      wr(OFF_STROBE_INPUT_CONTROL, 32'h0);
      $display("test strobe done");
      wr(OFF_CONTROL_STATUS, CS_BASE | 32'h01000000);
      chk("standby released", ram_standby, 1'b0);
      rd_chk("sync early", OFF_CONTROL_STATUS, 32'h01000000, 32'h0);
      repeat (60) @(posedge sys_clk);
      rd_chk("sync echo", OFF_CONTROL_STATUS, 32'h03000000, 32'h03000000);
      wr(OFF_RECEIVE_CONFIG, 32'h0000002f);
      wr(OFF_DMA_REQUEST_LEVEL, 32'h00000302);
      wr(OFF_CONTROL_STATUS, CS_BASE | 32'h2);
      wr(OFF_CONTROL_STATUS, 32'h00000003);
      chk("standby while running", ram_standby, 1'b0);
      rd_chk("sex kept", OFF_CONTROL_STATUS, 32'h02800202, 32'h02800202);
      chk("enables", {port_enable, rx_on, tx_on}, 3'b110);
      for (int i = 0; i < DEPTH_TB; i++)
         pcm(32'h00008001);
      @(posedge sys_clk);
      rd_chk("full flags", OFF_CONTROL_STATUS, 32'h00570000, 32'h00560000);
      chk("rx dma req", rx_dma_req, 1'b1);
      rx_mid_frame <= 1'b1;
      rd_chk("rx slip", OFF_CONTROL_STATUS, 32'h00006000, 32'h00002000);
      rx_mid_frame <= 1'b0;
      tx_mid_frame <= 1'b1;
      rd_chk("tx slip", OFF_CONTROL_STATUS, 32'h00006000, 32'h00004000);
      tx_mid_frame <= 1'b0;
      pcm(32'h00008001);
      @(posedge sys_clk);
      rd_chk("overflow", OFF_CONTROL_STATUS, 32'h00010000, 32'h00010000);
      wr(OFF_CONTROL_STATUS, 32'h00010003);
      rd_chk("err cleared", OFF_CONTROL_STATUS, 32'h00010000, 32'h0);
      for (int i = 0; i < DEPTH_TB; i++)
         rd_chk("extended word", OFF_FIFO_DATA_PORT, 32'hffffffff, 32'hffff8001);
      chk("rx dma idle", rx_dma_req, 1'b0);
      rd_chk("drained", OFF_CONTROL_STATUS, 32'h00540000, 32'h0);
      tx_pop <= 1'b1;
      @(posedge sys_clk);
      tx_pop <= 1'b0;
      @(posedge sys_clk);
      rd_chk("tx underflow", OFF_CONTROL_STATUS, 32'h00288000, 32'h00288000);
      chk("tx dma req", tx_dma_req, 1'b1);
      for (int i = 0; i < DEPTH_TB; i++)
         wr(OFF_FIFO_DATA_PORT, 32'h5a000000 | i);
      chk("tx head", tx_data, 32'h5a000000);
      chk("tx dma idle", tx_dma_req, 1'b0);
      rd_chk("tx full", OFF_CONTROL_STATUS, 32'h002a0000, 32'h0);
      $display("test fifo done");
      finish_test();
   end
endmodule
bind apsr_core apsr_core_chk chk_i (
   .sys_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .ram_standby, .rx_on, .tx_on
);

// [test/apsr_strobe_src.sv]
// Data/strobe source with free-running bit clock
`timescale 1ns/1ps
module apsr_strobe_src (
   output logic link_clk       = 1'b0,
   output logic data_pin       = 1'b0,
   output logic frame_sync_pin = 1'b0
);
   always #62.5 link_clk <= ~link_clk;
   // Sends the low n bits of w, most significant first
   task automatic send(input logic [31:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         repeat (4) @(posedge link_clk);
         @(negedge link_clk);
         // Exactly one line changes per bit; lines stay clean between edges
         if (data_pin == w[i])
            frame_sync_pin <= ~frame_sync_pin;
         else
            data_pin <= w[i];
      end
      repeat (4) @(posedge link_clk);
   endtask
endmodule
